/* File: shared/charger_regs_pkg.sv */
/*
 * constants of the fault alert mask and monitoring converter control block:
 * register offsets, field positions, reset values, clamp limits, state codes.
 * assumes byte-wide registers reached through the device's own register port.
 */
// Operation
// - input under-voltage mask bit 7, over-voltage bit 6; 0 alerts, 1 blocks; reset 0
// - battery over-current mask bit 5, over-voltage bit 4; 0 alerts, 1 blocks
// - thermal trip mask bit 3; 1 blocks its alert pulse, 0 allows it
// - safety timer mask bit 2; expiry rising edge alerts only when mask 0
// - gate supply mask bit 1 blocks supply fault alert; bit 0 reads 0
// - converter enable bit 7; cleared by register reset and watchdog expiry
// - rate select bit 6 resets to 1; 0 continuous, 1 single pass
// - speed field bits 5:4 resets 10b; 15, 14, 13 bits; 11b reserved
// - averaging bit 3: 0 single value, 1 running average per result
// - seed bit 2: 0 start from held value, 1 from new conversion; 1:0 reserved
// - channel skip bits 7,6,5,4,2,1; 0 includes, 1 skips; bit 3 reads 1
// - input current signed, 0.8 mA step, clamped 9e58h..61a8h, reads 0 at reset
// - battery current signed, 2 mA step, clamped d8f0h..2710h, reads 0 at reset
// - input voltage unsigned, 2 mV step, clamped 0..7fffh, reads 0 at reset
// - result low byte at base offset, high byte at next; host reads both
// - each gated fault flag sets on fault entry, clears when host reads it
// - pass completion may alert, unless masked, only in single-pass mode
package charger_regs_pkg;

	localparam logic [7:0] FLAG_OFFSET  = 8'h27;
	localparam logic [7:0] MASK_OFFSET  = 8'h2a;
	localparam logic [7:0] SETUP_OFFSET = 8'h2b;
	localparam logic [7:0] CHSEL_OFFSET = 8'h2c;
	localparam logic [7:0] IIN_OFFSET   = 8'h2d;
	localparam logic [7:0] IBAT_OFFSET  = 8'h2f;
	localparam logic [7:0] VIN_OFFSET   = 8'h31;

	localparam logic [7:0] FLAG_RESET  = 8'h00;
	localparam logic [7:0] MASK_RESET  = 8'h00;
	localparam logic [7:0] SETUP_RESET = 8'h60;
	localparam logic [7:0] CHSEL_RESET = 8'h0a;

	// bits software may change; the rest read their fixed value
	localparam logic [7:0] MASK_WRITABLE  = 8'hfe;
	localparam logic [7:0] SETUP_WRITABLE = 8'hfc;
	localparam logic [7:0] CHSEL_WRITABLE = 8'hf6;
	localparam logic [7:0] CHSEL_FIXED    = 8'h08;

	// fault events occupy bits 7..1 in flag and mask registers
	localparam int FAULT_COUNT = 7;
	localparam int FAULT_LSB   = 1;

	localparam int SETUP_ENABLE_BIT  = 7;
	localparam int SETUP_ONESHOT_BIT = 6;
	localparam int SETUP_SPEED_LSB   = 4;
	localparam int SETUP_AVG_BIT     = 3;
	localparam int SETUP_SEED_BIT    = 2;

	localparam logic [1:0] SPEED_15BIT    = 2'h0;
	localparam logic [1:0] SPEED_14BIT    = 2'h1;
	localparam logic [1:0] SPEED_13BIT    = 2'h2;
	localparam logic [1:0] SPEED_RESERVED = 2'h3;

	// channel scan order and the skip bit of each
	localparam int                NUM_CHANNELS = 6;
	localparam logic [2:0]        CHAN_IIN     = 3'h0;
	localparam logic [2:0]        CHAN_IBAT    = 3'h1;
	localparam logic [2:0]        CHAN_VIN     = 3'h2;
	localparam logic [2:0]        CHAN_END     = 3'h6;
	localparam int                CHAN_SKIP_BIT [NUM_CHANNELS] = '{7, 6, 5, 4, 2, 1};

	localparam logic signed [15:0] IIN_MIN  = 16'sh9e58;
	localparam logic signed [15:0] IIN_MAX  = 16'sh61a8;
	localparam logic signed [15:0] IBAT_MIN = 16'shd8f0;
	localparam logic signed [15:0] IBAT_MAX = 16'sh2710;
	localparam logic signed [15:0] VIN_MIN  = 16'sh0000;
	localparam logic signed [15:0] VIN_MAX  = 16'sh7fff;

	typedef enum logic [3:0]
	{
		SCAN_IDLE    = 4'b0001,
		SCAN_REQUEST = 4'b0010,
		SCAN_WAIT    = 4'b0100,
		SCAN_FINISH  = 4'b1000
	} scan_state_t;

endpackage

/* File: hdl/fault_edge_detect.sv */
/*
 * synchronises asynchronous fault levels and reports each rising edge
 * as a one-cycle pulse. assumes levels come from analog comparators.
 */
`timescale 1ns/1ps
module fault_edge_detect #(
	parameter int WIDTH = 7
)(
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] level_in,
	output      logic [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] settled;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			stage1 <= level_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a level change counts only when stages two and three agree
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			settled <= '0;
			rise    <= '0;
		end
		else
		begin
			settled <= (stage2 & stage3) | (settled & (stage2 | stage3));
			rise    <= stage2 & stage3 & ~settled;
		end
	end
endmodule

/* File: hdl/result_channel.sv */
/*
 * one converter result: clamps the raw code, optionally keeps a running
 * average, and holds the 16-bit reading. assumes one load pulse per sample.
 */
`timescale 1ns/1ps
module result_channel #(
	parameter logic signed [15:0] MIN_CODE = 16'sh8000,
	parameter logic signed [15:0] MAX_CODE = 16'sh7fff
)(
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic signed [15:0] sample,
	input  wire logic               load,
	input  wire logic               avg_en,
	input  wire logic               seed_fresh,
	output      logic [15:0]        value
);
	logic signed [15:0] clamped;
	logic signed [16:0] sum;

	always_comb
	begin
		if (sample < MIN_CODE)
			clamped = MIN_CODE;
		else if (sample > MAX_CODE)
			clamped = MAX_CODE;
		else
			clamped = sample;
		sum = {value[15], value} + {clamped[15], clamped};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			value <= 16'h0000;
		else if (load)
		begin
			if (avg_en && !seed_fresh)
				value <= sum[16:1];
			else
				value <= clamped;
		end
	end
endmodule

/* File: hdl/charger_monitor_regs.sv */
/*
 * fault alert mask, fault flags and monitoring converter control with the
 * input current, battery current and input voltage readings.
 * assumes the device's serial engine turns host transfers into byte reads
 * and writes on the register port, and that the converter core, watchdog
 * and fault comparators sit beside it on the same board of logic.
 */
`timescale 1ns/1ps
module charger_monitor_regs
(
	input  wire logic                                   CLK,
	input  wire logic                                   SRST,
	input  wire logic [7:0]                             REG_ADDR,
	input  wire logic [7:0]                             REG_WDATA,
	input  wire logic                                   REG_WR,
	input  wire logic                                   REG_RD,
	output      logic [7:0]                             REG_RDATA,
	input  wire logic [charger_regs_pkg::FAULT_COUNT-1:0] FAULT_LEVEL,
	input  wire logic                                   WDOG_EXPIRE,
	input  wire logic                                   DONE_ALERT_BLOCK,
	output      logic                                   CONV_ON,
	output      logic [1:0]                             CONV_SPEED,
	output      logic                                   CONV_REQ,
	output      logic [2:0]                             CONV_CHAN,
	input  wire logic                                   SAMPLE_VALID,
	input  wire logic signed [15:0]                     SAMPLE_DATA,
	output      logic                                   ALERT_PULSE,
	output      logic                                   PASS_DONE
);
	import charger_regs_pkg::*;

	logic [7:0]                 alert_mask;
	logic [7:0]                 setup;
	logic [7:0]                 chan_skip;
	logic [FAULT_COUNT-1:0]     fault_flag;
	logic [FAULT_COUNT-1:0]     fault_rise;
	scan_state_t                state;
	logic [2:0]                 chan_idx;
	logic                       first_pass;
	logic                       pass_end;
	logic                       oneshot_clear;
	logic [15:0]                iin_value;
	logic [15:0]                ibat_value;
	logic [15:0]                vin_value;
	logic [7:0]                 iin_high;
	logic [7:0]                 ibat_high;
	logic [7:0]                 vin_high;
	logic                       chan_is_skipped;
	logic                       seed_fresh;
	logic                       wr_mask;
	logic                       wr_setup;
	logic                       wr_chsel;
	logic                       rd_flag;
	logic [7:0]                 next_rdata;
	logic                       load_iin;
	logic                       load_ibat;
	logic                       load_vin;
	logic                       fault_alert;
	logic                       done_alert;
	logic                       next_req;

	assign wr_mask  = REG_WR && (REG_ADDR == MASK_OFFSET);
	assign wr_setup = REG_WR && (REG_ADDR == SETUP_OFFSET);
	assign wr_chsel = REG_WR && (REG_ADDR == CHSEL_OFFSET);
	assign rd_flag  = REG_RD && (REG_ADDR == FLAG_OFFSET);

	// a sample lands only in the wait state, in the reading of the channel asked for
	assign load_iin  = (state == SCAN_WAIT) && SAMPLE_VALID && (chan_idx == CHAN_IIN);
	assign load_ibat = (state == SCAN_WAIT) && SAMPLE_VALID && (chan_idx == CHAN_IBAT);
	assign load_vin  = (state == SCAN_WAIT) && SAMPLE_VALID && (chan_idx == CHAN_VIN);

	fault_edge_detect #(
		.WIDTH (FAULT_COUNT)
	) u_fault_edges (
		.clk      (CLK),
		.srst     (SRST),
		.level_in (FAULT_LEVEL),
		.rise     (fault_rise)
	);

	// alert mask; bit 0 stays zero
	always_ff @(posedge CLK)
	begin
		if (SRST)
			alert_mask <= MASK_RESET;
		else if (wr_mask)
			alert_mask <= REG_WDATA & MASK_WRITABLE;
	end

	// converter setup; watchdog beats a host write, a host write beats the one-shot clear
	always_ff @(posedge CLK)
	begin
		if (SRST)
			setup <= SETUP_RESET;
		else
		begin
			if (wr_setup)
				setup <= REG_WDATA & SETUP_WRITABLE;
			else if (oneshot_clear)
				setup[SETUP_ENABLE_BIT] <= 1'b0;
			if (WDOG_EXPIRE)
				setup[SETUP_ENABLE_BIT] <= 1'b0;
		end
	end

	// channel skip bits; bit 3 reads 1, bit 0 reads 0
	always_ff @(posedge CLK)
	begin
		if (SRST)
			chan_skip <= CHSEL_RESET;
		else if (wr_chsel)
			chan_skip <= (REG_WDATA & CHSEL_WRITABLE) | CHSEL_FIXED;
	end

	// fault flags clear on read, a new fault in the same cycle still sets
	always_ff @(posedge CLK)
	begin
		if (SRST)
			fault_flag <= FLAG_RESET[FAULT_LSB +: FAULT_COUNT];
		else
			fault_flag <= (rd_flag ? '0 : fault_flag) | fault_rise;
	end

	// alert pulse on any cycle with an unmasked fault entry or single-pass completion
	assign fault_alert = |(fault_rise & ~alert_mask[FAULT_LSB +: FAULT_COUNT]);
	assign done_alert  = oneshot_clear && !DONE_ALERT_BLOCK;

	always_ff @(posedge CLK)
	begin
		if (SRST)
			ALERT_PULSE <= 1'b0;
		else
			ALERT_PULSE <= fault_alert || done_alert;
	end

	// converter controls come straight from the setup register
	assign CONV_ON    = setup[SETUP_ENABLE_BIT];
	assign CONV_SPEED = setup[SETUP_SPEED_LSB +: 2];

	always_comb
	begin
		chan_is_skipped = 1'b1;
		for (int k = 0; k < NUM_CHANNELS; k++)
		begin
			if (chan_idx == 3'(k))
				chan_is_skipped = chan_skip[CHAN_SKIP_BIT[k]];
		end
	end

	// a one-shot pass clears its own enable at the finish
	assign pass_end      = (state == SCAN_FINISH);
	assign oneshot_clear = pass_end && setup[SETUP_ONESHOT_BIT];
	assign seed_fresh    = first_pass && setup[SETUP_SEED_BIT];

	// channel scan: request each included channel in turn, wait for its sample
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			state    <= SCAN_IDLE;
			chan_idx <= 3'h0;
		end
		else
		begin
			// dropping the enable abandons the pass at once
			if (!CONV_ON)
			begin
				state    <= SCAN_IDLE;
				chan_idx <= 3'h0;
			end
			else
			begin
				unique case (state)
					SCAN_IDLE:
					begin
						chan_idx <= 3'h0;
						state    <= SCAN_REQUEST;
					end
					SCAN_REQUEST:
					begin
						if (chan_idx == CHAN_END)
							state <= SCAN_FINISH;
						else if (chan_is_skipped)
							chan_idx <= chan_idx + 3'h1;
						else
							state <= SCAN_WAIT;
					end
					SCAN_WAIT:
					begin
						if (SAMPLE_VALID)
						begin
							chan_idx <= chan_idx + 3'h1;
							state    <= SCAN_REQUEST;
						end
					end
					SCAN_FINISH:
					begin
						chan_idx <= 3'h0;
						state    <= setup[SETUP_ONESHOT_BIT] ? SCAN_IDLE : SCAN_REQUEST;
					end
					default:
						state <= SCAN_IDLE;
				endcase
			end
		end
	end

	assign CONV_CHAN = chan_idx;

	// ask for a sample only for an included channel
	assign next_req = CONV_ON && (state == SCAN_REQUEST) && (chan_idx != CHAN_END) && !chan_is_skipped;

	always_ff @(posedge CLK)
	begin
		if (SRST)
			CONV_REQ <= 1'b0;
		else
			CONV_REQ <= next_req;
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			PASS_DONE <= 1'b0;
		else
			PASS_DONE <= pass_end;
	end

	// first pass after enabling seeds the average from a fresh sample
	always_ff @(posedge CLK)
	begin
		if (SRST || !CONV_ON)
			first_pass <= 1'b1;
		else if (pass_end)
			first_pass <= 1'b0;
	end

	result_channel #(
		.MIN_CODE (IIN_MIN),
		.MAX_CODE (IIN_MAX)
	) u_iin (
		.clk        (CLK),
		.srst       (SRST),
		.sample     (SAMPLE_DATA),
		.load       (load_iin),
		.avg_en     (setup[SETUP_AVG_BIT]),
		.seed_fresh (seed_fresh),
		.value      (iin_value)
	);

	result_channel #(
		.MIN_CODE (IBAT_MIN),
		.MAX_CODE (IBAT_MAX)
	) u_ibat (
		.clk        (CLK),
		.srst       (SRST),
		.sample     (SAMPLE_DATA),
		.load       (load_ibat),
		.avg_en     (setup[SETUP_AVG_BIT]),
		.seed_fresh (seed_fresh),
		.value      (ibat_value)
	);

	result_channel #(
		.MIN_CODE (VIN_MIN),
		.MAX_CODE (VIN_MAX)
	) u_vin (
		.clk        (CLK),
		.srst       (SRST),
		.sample     (SAMPLE_DATA),
		.load       (load_vin),
		.avg_en     (setup[SETUP_AVG_BIT]),
		.seed_fresh (seed_fresh),
		.value      (vin_value)
	);

	// reading a low byte freezes its high byte for the following read
	always_ff @(posedge CLK)
	begin
		if (SRST)
			iin_high <= 8'h00;
		else if (REG_RD && (REG_ADDR == IIN_OFFSET))
			iin_high <= iin_value[15:8];
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			ibat_high <= 8'h00;
		else if (REG_RD && (REG_ADDR == IBAT_OFFSET))
			ibat_high <= ibat_value[15:8];
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			vin_high <= 8'h00;
		else if (REG_RD && (REG_ADDR == VIN_OFFSET))
			vin_high <= vin_value[15:8];
	end

	// readback; unmapped addresses read zero
	always_comb
	begin
		unique case (REG_ADDR)
			FLAG_OFFSET:        next_rdata = {fault_flag, 1'b0};
			MASK_OFFSET:        next_rdata = alert_mask;
			SETUP_OFFSET:       next_rdata = setup;
			CHSEL_OFFSET:       next_rdata = chan_skip;
			IIN_OFFSET:         next_rdata = iin_value[7:0];
			IIN_OFFSET + 8'h1:  next_rdata = iin_high;
			IBAT_OFFSET:        next_rdata = ibat_value[7:0];
			IBAT_OFFSET + 8'h1: next_rdata = ibat_high;
			VIN_OFFSET:         next_rdata = vin_value[7:0];
			VIN_OFFSET + 8'h1:  next_rdata = vin_high;
			default:            next_rdata = 8'h00;
		endcase
	end

	// read data holds until the next read strobe
	always_ff @(posedge CLK)
	begin
		if (SRST)
			REG_RDATA <= 8'h00;
		else if (REG_RD)
			REG_RDATA <= next_rdata;
	end
endmodule

/* File: bench/charger_monitor_regs_sva.sv */
/*
 * assertions on the register port, converter scan and alert outputs.
 * assumes binding to charger_monitor_regs and sight of its ports only.
 */
`timescale 1ns/1ps
module charger_monitor_regs_sva
(
	input wire logic	CLK,
	input wire logic	SRST,
	input wire logic [7:0]	REG_ADDR,
	input wire logic [7:0]	REG_WDATA,
	input wire logic	REG_WR,
	input wire logic	REG_RD,
	input wire logic [7:0]	REG_RDATA,
	input wire logic	WDOG_EXPIRE,
	input wire logic	CONV_ON,
	input wire logic [1:0]	CONV_SPEED,
	input wire logic	CONV_REQ,
	input wire logic [2:0]	CONV_CHAN,
	input wire logic	ALERT_PULSE
);
	import charger_regs_pkg::*;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	chk_alert_one_cycle: assert property (ALERT_PULSE |=> !ALERT_PULSE)
		else $error("alert pulse longer than one cycle");
	chk_req_chan_pulse: assert property (CONV_REQ |-> CONV_CHAN < CHAN_END ##1 !CONV_REQ)
		else $error("bad converter request");
	chk_wdog_clears_on: assert property (WDOG_EXPIRE |=> !CONV_ON)
		else $error("watchdog left converter on");
	chk_setup_write: assert property (REG_WR && REG_ADDR == SETUP_OFFSET && !WDOG_EXPIRE |=>
		CONV_ON == $past(REG_WDATA[7]) && CONV_SPEED == $past(REG_WDATA[5:4]))
		else $error("setup write not applied");
	chk_rdata_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data changed without read");
	chk_reset_values: assert property ($fell(SRST) |-> !CONV_ON && CONV_SPEED == 2'h2)
		else $error("wrong setup after reset");
	chk_setup_reserved: assert property (REG_RD && REG_ADDR == SETUP_OFFSET |=> REG_RDATA[1:0] == 2'h0)
		else $error("setup reserved bits not zero");
	chk_chsel_fixed: assert property (REG_RD && REG_ADDR == CHSEL_OFFSET |=> REG_RDATA[3] && !REG_RDATA[0])
		else $error("channel select fixed bits wrong");
	chk_mask_reserved: assert property (REG_RD && REG_ADDR == MASK_OFFSET |=> !REG_RDATA[0])
		else $error("mask bit 0 not zero");
endmodule

bind charger_monitor_regs charger_monitor_regs_sva chk_u (.CLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR,
	.REG_RD, .REG_RDATA, .WDOG_EXPIRE, .CONV_ON, .CONV_SPEED, .CONV_REQ, .CONV_CHAN, .ALERT_PULSE);

/* File: bench/conv_core_model.sv */
/*
 * behavioural converter core: answers each request lag+1 cycles after taking it.
 * assumes one request outstanding; channels 3..5 return zero.
 */
`timescale 1ns/1ps
module conv_core_model (
	input wire logic		clk,
	input wire logic		srst,
	input wire logic		conv_req,
	input wire logic [2:0]		conv_chan,
	input wire logic [3:0]		lag,
	input wire logic [2:0][15:0]	codes,
	output logic			sample_valid,
	output logic signed [15:0]	sample_data
);
	logic		busy;
	logic [3:0]	cnt;
	logic [2:0]	chan;

	always_ff @(posedge clk)
	begin
		sample_valid <= 1'b0;
		// data is junk outside the valid cycle
		sample_data <= ~sample_data;
		if (srst)
			busy <= 1'b0;
		else if (conv_req)
		begin
			busy <= 1'b1;
			cnt <= lag;
			chan <= conv_chan;
		end
		else if (busy && cnt == 4'h0)
		begin
			busy <= 1'b0;
			sample_valid <= 1'b1;
			sample_data <= (chan < 3'h3) ? codes[chan[1:0]] : 16'h0000;
		end
		else if (busy)
			cnt <= cnt - 4'h1;
	end
endmodule

/* File: bench/charger_monitor_regs_tb.sv */
/*
 * self-checking bench of charger_monitor_regs: registers, faults, scans.
 * assumes conv_core_model stands in for the converter core.
 */
`timescale 1ns/1ps
module charger_monitor_regs_tb;
	import charger_regs_pkg::*;
	logic			CLK;
	logic			SRST;
	logic [7:0]		REG_ADDR;
	logic [7:0]		REG_WDATA;
	logic			REG_WR;
	logic			REG_RD;
	logic [7:0]		REG_RDATA;
	logic [6:0]		FAULT_LEVEL;
	logic			WDOG_EXPIRE;
	logic			DONE_ALERT_BLOCK;
	logic			CONV_ON;
	logic [1:0]		CONV_SPEED;
	logic			CONV_REQ;
	logic [2:0]		CONV_CHAN;
	logic			SAMPLE_VALID;
	logic signed [15:0]	SAMPLE_DATA;
	logic			ALERT_PULSE;
	logic			PASS_DONE;
	logic [2:0][15:0]	codes;
	int			failures;
	int			checks;
	int			alerts;
	int			passes;

	charger_monitor_regs dut_u (.CLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
		.FAULT_LEVEL, .WDOG_EXPIRE, .DONE_ALERT_BLOCK, .CONV_ON, .CONV_SPEED, .CONV_REQ, .CONV_CHAN,
		.SAMPLE_VALID, .SAMPLE_DATA, .ALERT_PULSE, .PASS_DONE);
	conv_core_model conv_u (.clk(CLK), .srst(SRST), .conv_req(CONV_REQ), .conv_chan(CONV_CHAN),
		.lag(4'h3), .codes(codes), .sample_valid(SAMPLE_VALID), .sample_data(SAMPLE_DATA));

	initial
	begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	always @(posedge CLK)
	begin
		if (ALERT_PULSE === 1'b1)
			alerts++;
		if (PASS_DONE === 1'b1)
			passes++;
	end

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(negedge CLK);
		REG_WR = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge CLK);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(negedge CLK);
		REG_RD = 1'b0;
		d = REG_RDATA;
	endtask

	// low byte first: it snapshots the high byte
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 8'h1, v[15:8]);
	endtask

	task automatic run_pass(input logic [7:0] setup);
		int n;
		n = 0;
		alerts = 0;
		passes = 0;
		wr(8'h2b, setup);
		while (passes == 0 && n < 500)
		begin
			@(negedge CLK);
			n++;
		end
		if (passes == 0)
		begin
			$display("mismatch pass_done expected 1 seen 0");
			failures++;
			print_verdict();
		end
		repeat (3) @(negedge CLK);
	endtask

	task automatic t_reset();
		logic [7:0] a [11] = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h27, 8'h40};
		logic [7:0] e [11] = '{8'h00, 8'h60, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [7:0] d;
		for (int i = 0; i < 11; i++)
		begin
			rd(a[i], d);
			chk("reset value", {8'h00, e[i]}, {8'h00, d});
		end
		$display("test reset done");
	endtask

	task automatic t_access();
		logic [7:0] d;
		wr(8'h2a, 8'hff);
		rd(8'h2a, d);
		chk("mask access", 16'h00fe, {8'h00, d});
		wr(8'h2b, 8'h3f);
		rd(8'h2b, d);
		chk("setup access", 16'h003c, {8'h00, d});
		chk("speed field", 16'h0003, {14'h0, CONV_SPEED});
		wr(8'h2c, 8'hff);
		rd(8'h2c, d);
		chk("chsel access", 16'h00fe, {8'h00, d});
		wr(8'h40, 8'h55);
		rd(8'h40, d);
		chk("unmapped", 16'h0000, {8'h00, d});
		// feedback channel stays off, as the host must keep it
		wr(8'h2c, 8'h0a);
		wr(8'h2b, 8'h60);
		$display("test access done");
	endtask

	task automatic t_faults();
		logic [7:0] d;
		for (int m = 0; m < 2; m++)
			for (int i = 0; i < 7; i++)
			begin
				wr(8'h2a, m ? 8'hfe : 8'h00);
				alerts = 0;
				FAULT_LEVEL[i] = 1'b1;
				repeat (10) @(negedge CLK);
				chk("fault alert", m ? 16'h0 : 16'h1, 16'(alerts));
				rd(8'h27, d);
				chk("fault flag", 16'(8'h1 << (i + 1)), {8'h00, d});
				rd(8'h27, d);
				chk("flag after read", 16'h0, {8'h00, d});
				FAULT_LEVEL[i] = 1'b0;
				repeat (6) @(negedge CLK);
			end
		$display("test faults done");
	endtask

	task automatic t_scans();
		logic [15:0] v;
		logic [7:0] d;
		codes = {16'hfff0, 16'h7fff, 16'h8000};
		run_pass(8'hc0);
		chk("oneshot alert", 16'h1, 16'(alerts));
		chk("enable cleared", 16'h0, {15'h0, CONV_ON});
		rd16(8'h2d, v);
		chk("iin clamp", 16'h9e58, v);
		rd16(8'h2f, v);
		chk("ibat clamp", 16'h2710, v);
		rd16(8'h31, v);
		chk("vin clamp", 16'h0000, v);
		codes = {16'h0100, 16'h0000, 16'h0000};
		DONE_ALERT_BLOCK = 1'b1;
		run_pass(8'hc8);
		chk("blocked alert", 16'h0, 16'(alerts));
		rd16(8'h2d, v);
		chk("iin average", 16'hcf2c, v);
		rd16(8'h2f, v);
		chk("ibat average", 16'h1388, v);
		rd16(8'h31, v);
		chk("vin average", 16'h0080, v);
		codes = {16'h0030, 16'h0020, 16'h0010};
		// battery channel off, as the host must while the load sink is on
		wr(8'h2c, 8'h4a);
		run_pass(8'hcc);
		// high byte alone still shows the copy taken at the last low read
		rd(8'h2e, d);
		chk("iin high latched", 16'h00cf, {8'h00, d});
		rd16(8'h2d, v);
		chk("iin fresh seed", 16'h0010, v);
		rd16(8'h2f, v);
		chk("ibat skipped", 16'h1388, v);
		rd16(8'h31, v);
		chk("vin fresh seed", 16'h0030, v);
		wr(8'h2c, 8'h0a);
		DONE_ALERT_BLOCK = 1'b0;
		alerts = 0;
		wr(8'h2b, 8'h80);
		repeat (200) @(negedge CLK);
		chk("continuous alert", 16'h0, 16'(alerts));
		chk("continuous on", 16'h1, {15'h0, CONV_ON});
		WDOG_EXPIRE = 1'b1;
		@(negedge CLK);
		WDOG_EXPIRE = 1'b0;
		@(negedge CLK);
		chk("watchdog off", 16'h0, {15'h0, CONV_ON});
		$display("test scans done");
	endtask

	initial
	begin
		#200000;
		$display("mismatch timeout expected done seen running");
		failures++;
		print_verdict();
	end

	initial
	begin
		{SRST, REG_ADDR, REG_WDATA, REG_WR, REG_RD} = {1'b1, 18'h0};
		{FAULT_LEVEL, WDOG_EXPIRE, DONE_ALERT_BLOCK} = 9'h0;
		codes = '0;
		failures = 0;
		checks = 0;
		repeat (6) @(negedge CLK);
		SRST = 1'b0;
		repeat (6) @(negedge CLK);
		t_reset();
		t_access();
		t_faults();
		t_scans();
		print_verdict();
	end
endmodule
